// *** common/nmsp_pkg.sv ***
package nmsp_pkg;
  // Port addresses
  localparam logic [15:0] NMSP_STATUS_PORT = 16'h0061;
  localparam logic [15:0] NMSP_MASK_PORT = 16'h0070;
  // Status/control field positions
  localparam int NMSP_BIT_SERR_STS = 7;
  localparam int NMSP_BIT_CHK_STS = 6;
  localparam int NMSP_BIT_CNT2_OUT = 5;
  localparam int NMSP_BIT_REFRESH = 4;
  localparam int NMSP_BIT_CHK_DIS = 3;
  localparam int NMSP_BIT_SERR_DIS = 2;
  localparam int NMSP_BIT_SPK_EN = 1;
  localparam int NMSP_BIT_CNT2_GATE = 0;
  localparam int NMSP_BIT_NMI_MASK = 7;
  // Reset values
  localparam logic [3:0] NMSP_CTRL_RESET = 4'h0;
  localparam logic NMSP_MASK_RESET = 1'b1;
endpackage

// *** rtl/nmsp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module nmsp_sync (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// *** rtl/nmsp_nmi_ctrl.sv ***
// Functional notes
// - System error pulse sets status bit 7
// - Channel check sets status bit 6
// - Bit 3 zero enables; one clears, disables
// - Bit 2 zero enables; one clears, disables
// - Bit 5 reads live counter 2 output
// - Bit 4 toggles after each refresh
// - Speaker is counter 2 output when enabled
// - Bit 0 drives counter 2 gate
// - Port 061h resets to zero
// - Port 070h bit 7 masks NMI, resets 1
// - Port 070h bits 6:0 ignored here
// - Port 070h accesses forwarded to ISA
// - Mask toggle gives fresh NMI edge
`timescale 1ns/10ps
`default_nettype none
module nmsp_nmi_ctrl (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Host I/O port access, one-cycle strobes
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_rvalid,
  // ISA forwarding of the mask/index port
  output logic o_isa_fwd_wr,
  output logic o_isa_fwd_rd,
  output logic [7:0] o_isa_fwd_data,
  // Error sources from pins, active low
  input wire logic i_serr_n,
  input wire logic i_iochk_n,
  // Timer and refresh
  input wire logic i_cnt2_out,
  input wire logic i_refresh_done,
  output logic o_cnt2_gate,
  output logic o_speaker_out,
  // Interrupt output
  output logic o_nmi
);
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic serr_sync;
  logic iochk_sync;
  logic cnt2_sync;

  nmsp_sync u_sync_serr (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(~i_serr_n),
    .o_sync(serr_sync)
  );
  nmsp_sync u_sync_iochk (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(~i_iochk_n),
    .o_sync(iochk_sync)
  );
  nmsp_sync u_sync_cnt2 (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_cnt2_out),
    .o_sync(cnt2_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  logic serr_sts_reg;
  logic serr_sts_next;
  logic chk_sts_reg;
  logic chk_sts_next;
  logic refresh_tgl_reg;
  logic refresh_tgl_next;
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic mask_reg;
  logic mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic fwd_wr_reg;
  logic fwd_wr_next;
  logic fwd_rd_reg;
  logic fwd_rd_next;
  logic [7:0] fwd_data_reg;
  logic [7:0] fwd_data_next;
  logic gate_reg;
  logic gate_next;
  logic spk_reg;
  logic spk_next;
  logic nmi_reg;
  logic nmi_next;
  logic wr_status;
  logic wr_mask;
  logic rd_status;
  logic rd_mask;

  always_comb begin
    wr_status = i_io_wr && (i_io_addr == nmsp_pkg::NMSP_STATUS_PORT);
    wr_mask = i_io_wr && (i_io_addr == nmsp_pkg::NMSP_MASK_PORT);
    rd_status = i_io_rd && (i_io_addr == nmsp_pkg::NMSP_STATUS_PORT);
    rd_mask = i_io_rd && (i_io_addr == nmsp_pkg::NMSP_MASK_PORT);
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    // Only the writable low nibble is stored
    if (wr_status) begin
      ctrl_next = i_io_wdata[3:0];
    end
    // Only the mask bit is kept; index bits pass on to ISA
    if (wr_mask) begin
      mask_next = i_io_wdata[nmsp_pkg::NMSP_BIT_NMI_MASK];
    end
    // Latch while enabled; clear while disable bit is set
    serr_sts_next = serr_sts_reg;
    if (ctrl_next[nmsp_pkg::NMSP_BIT_SERR_DIS]) begin
      serr_sts_next = 1'b0;
    end else if (serr_sync) begin
      serr_sts_next = 1'b1;
    end
    chk_sts_next = chk_sts_reg;
    if (ctrl_next[nmsp_pkg::NMSP_BIT_CHK_DIS]) begin
      chk_sts_next = 1'b0;
    end else if (iochk_sync) begin
      chk_sts_next = 1'b1;
    end
    refresh_tgl_next = refresh_tgl_reg ^ i_refresh_done;
    // Read data captured from current state
    rdata_next = rdata_reg;
    if (rd_status) begin
      rdata_next = {serr_sts_reg, chk_sts_reg, cnt2_sync, refresh_tgl_reg,
                    ctrl_reg};
    end else if (rd_mask) begin
      rdata_next = 8'h00;
    end
    rvalid_next = rd_status;
    fwd_wr_next = wr_mask;
    fwd_rd_next = rd_mask;
    fwd_data_next = wr_mask ? i_io_wdata : fwd_data_reg;
    gate_next = ctrl_next[nmsp_pkg::NMSP_BIT_CNT2_GATE];
    spk_next = ctrl_next[nmsp_pkg::NMSP_BIT_SPK_EN] & cnt2_sync;
    // Mask set drops the line; clearing it re-raises if pending
    nmi_next = ~mask_next & ((serr_sts_next & ~ctrl_next[nmsp_pkg::NMSP_BIT_SERR_DIS]) |
                             (chk_sts_next & ~ctrl_next[nmsp_pkg::NMSP_BIT_CHK_DIS]));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_reg <= nmsp_pkg::NMSP_CTRL_RESET;
      mask_reg <= nmsp_pkg::NMSP_MASK_RESET;
      serr_sts_reg <= 1'b0;
      chk_sts_reg <= 1'b0;
      refresh_tgl_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      fwd_wr_reg <= 1'b0;
      fwd_rd_reg <= 1'b0;
      fwd_data_reg <= 8'h00;
      gate_reg <= 1'b0;
      spk_reg <= 1'b0;
      nmi_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      serr_sts_reg <= serr_sts_next;
      chk_sts_reg <= chk_sts_next;
      refresh_tgl_reg <= refresh_tgl_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      fwd_wr_reg <= fwd_wr_next;
      fwd_rd_reg <= fwd_rd_next;
      fwd_data_reg <= fwd_data_next;
      gate_reg <= gate_next;
      spk_reg <= spk_next;
      nmi_reg <= nmi_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_io_rdata = rdata_reg;
  assign o_io_rvalid = rvalid_reg;
  assign o_isa_fwd_wr = fwd_wr_reg;
  assign o_isa_fwd_rd = fwd_rd_reg;
  assign o_isa_fwd_data = fwd_data_reg;
  assign o_cnt2_gate = gate_reg;
  assign o_speaker_out = spk_reg;
  assign o_nmi = nmi_reg;
endmodule
`default_nettype wire

// *** verification/nmsp_nmi_ctrl_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module nmsp_nmi_ctrl_chk (
  input wire logic i_clock, i_rst_n, i_io_wr, i_io_rd, i_serr_n, i_iochk_n,
  input wire logic i_cnt2_out, i_refresh_done, o_io_rvalid, o_isa_fwd_wr,
  input wire logic o_isa_fwd_rd, o_cnt2_gate, o_speaker_out, o_nmi,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata, o_io_rdata, o_isa_fwd_data
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_w61; i_io_wr && i_io_addr == 16'h0061; endsequence
  sequence s_w70; i_io_wr && i_io_addr == 16'h0070; endsequence
  property p_rd; i_io_rd && i_io_addr == 16'h0061 |=> o_io_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_fwd; s_w70 |=> o_isa_fwd_wr && o_isa_fwd_data == $past(i_io_wdata); endproperty
  a_fwd: assert property (p_fwd) else $error("bad write forward");
  property p_fwdrd; i_io_rd && i_io_addr == 16'h0070 |=> o_isa_fwd_rd && !o_io_rvalid; endproperty
  a_fwdrd: assert property (p_fwdrd) else $error("bad read forward");
  property p_gate; s_w61 |=> o_cnt2_gate == $past(i_io_wdata[0]); endproperty
  a_gate: assert property (p_gate) else $error("gate wrong");
  property p_spk; s_w61 ##0 !i_io_wdata[1] |=> !o_speaker_out; endproperty
  a_spk: assert property (p_spk) else $error("speaker not off");
  property p_clr2; o_io_rvalid && o_io_rdata[2] |-> !o_io_rdata[7]; endproperty
  a_clr2: assert property (p_clr2) else $error("status 7 not clear");
  property p_clr3; o_io_rvalid && o_io_rdata[3] |-> !o_io_rdata[6]; endproperty
  a_clr3: assert property (p_clr3) else $error("status 6 not clear");
  property p_mask; s_w70 ##0 i_io_wdata[7] |=> !o_nmi; endproperty
  a_mask: assert property (p_mask) else $error("mask ignored");
endmodule
bind nmsp_nmi_ctrl nmsp_nmi_ctrl_chk chk_u (.*);
`default_nettype wire

// *** verification/nmsp_cnt2_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module nmsp_cnt2_model #(parameter int HALF = 4) (
  input wire logic i_clock,
  input wire logic i_gate,
  output logic o_out
);
  int cnt = 0;
  initial o_out = 1'b0;
  // Square wave only while gated on
  always @(posedge i_clock) begin
    if (i_gate) cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (i_gate && cnt == HALF - 1) o_out <= ~o_out;
  end
endmodule
`default_nettype wire

// *** verification/tb_nmsp_nmi_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_nmsp_nmi_ctrl;
  logic i_clock = 0, i_rst_n = 0, i_io_wr = 0, i_io_rd = 0;
  logic i_serr_n = 1, i_iochk_n = 1, i_refresh_done = 0, i_cnt2_out;
  logic o_io_rvalid, o_isa_fwd_wr, o_isa_fwd_rd, o_cnt2_gate, o_speaker_out, o_nmi;
  logic [15:0] i_io_addr = 16'h0000;
  logic [7:0] i_io_wdata = 8'h00, o_io_rdata, o_isa_fwd_data;
  int err_count = 0, total_checks = 0, cyc = 0;
  nmsp_nmi_ctrl dut_u (.*);
  nmsp_cnt2_model #(.HALF(4)) cnt2_u (.i_clock(i_clock), .i_gate(o_cnt2_gate), .o_out(i_cnt2_out));
  initial forever #10 i_clock = ~i_clock;
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_io_wr <= w;
    i_io_rd <= !w;
    i_io_addr <= a;
    i_io_wdata <= d;
    @(posedge i_clock);
    i_io_wr <= 1'b0;
    i_io_rd <= 1'b0;
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] m, input logic [7:0] e);
    acc(1'b0, 16'h0061, 8'h00);
    chk(o_io_rdata & m, e);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(8'hFF, 8'h00);
    acc(1'b1, 16'h0070, 8'h00);
    chk(o_isa_fwd_data, 8'h00);
    acc(1'b0, 16'h0070, 8'h00);
    acc(1'b0, 16'h0062, 8'h00);
    chk(8'(o_io_rvalid), 8'h00);
    i_serr_n <= 1'b0;
    idle(3);
    i_serr_n <= 1'b1;
    idle(3);
    rd(8'hC0, 8'h80);
    chk(8'(o_nmi), 8'h01);
    acc(1'b1, 16'h0070, 8'h80);
    idle(1);
    chk(8'(o_nmi), 8'h00);
    acc(1'b1, 16'h0070, 8'h00);
    idle(1);
    chk(8'(o_nmi), 8'h01);
    acc(1'b1, 16'h0061, 8'h04);
    idle(1);
    rd(8'hCF, 8'h04);
    chk(8'(o_nmi), 8'h00);
    acc(1'b1, 16'h0061, 8'h00);
    i_iochk_n <= 1'b0;
    idle(4);
    rd(8'hC0, 8'h40);
    acc(1'b1, 16'h0061, 8'h08);
    idle(4);
    rd(8'hC0, 8'h00);
    i_iochk_n <= 1'b1;
    i_refresh_done <= 1'b1;
    idle(1);
    i_refresh_done <= 1'b0;
    idle(1);
    rd(8'h10, 8'h10);
    acc(1'b1, 16'h0061, 8'h03);
    chk(8'(o_cnt2_gate), 8'h01);
    idle(8);
    chk(8'(o_speaker_out), 8'h01);
    idle(4);
    acc(1'b1, 16'h0061, 8'h01);
    idle(1);
    chk(8'(o_speaker_out), 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
